// ---- core/ethib_addr_filter.v ----
`timescale 1ns/1ps
`include "ethib_defs.vh"

module ethib_addr_filter (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        check_i,
  input  wire [47:0] dest_i,
  input  wire        from_net_i,
  input  wire        rx_enable_i,
  input  wire        accept_all_i,
  input  wire        internal_only_i,
  input  wire [47:0] station_i,
  input  wire [63:0] hash_mask_i,
  output reg         accept_o,
  output reg         done_o
);

  localparam [2:0] ST_IDLE   = 3'b001;
  localparam [2:0] ST_HASH   = 3'b010;
  localparam [2:0] ST_DECIDE = 3'b100;

  reg  [2:0]  state_reg;
  reg  [47:0] shift_reg;
  reg  [5:0]  count_reg;
  wire [31:0] crc_value;
  wire        start_hash;
  wire        is_group;
  wire        is_broadcast;

  assign is_group     = dest_i[0];
  assign is_broadcast = &dest_i;
  // A hash run starts only for a group address that no earlier test settles.
  assign start_hash   = (state_reg == ST_IDLE) && check_i && rx_enable_i &&
                        !(from_net_i && internal_only_i) && !accept_all_i &&
                        is_group && !is_broadcast;

  // The shared generator hashes the destination address.
  ethib_crc32 u_crc (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .clear_i     (start_hash),
    .bit_valid_i (state_reg == ST_HASH),
    .bit_i       (shift_reg[0]),
    .crc_o       (crc_value)
  );

  // Decision sequencer; a check offered while busy is ignored.
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= ST_IDLE;
      shift_reg <= 48'h000000000000;
      count_reg <= 6'h00;
      accept_o  <= 1'b0;
      done_o    <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (check_i)
          begin
            if (!rx_enable_i)
            begin
              accept_o <= 1'b0; // see RULE_18
              done_o   <= 1'b1;
            end
            else if (from_net_i && internal_only_i)
            begin
              accept_o <= 1'b0; // see RULE_15
              done_o   <= 1'b1;
            end
            else if (accept_all_i)
            begin
              accept_o <= 1'b1; // see RULE_05
              done_o   <= 1'b1;
            end
            else if (!is_group)
            begin
              accept_o <= (dest_i == station_i); // see RULE_20
              done_o   <= 1'b1;
            end
            else if (is_broadcast)
            begin
              accept_o <= 1'b1; // see RULE_21
              done_o   <= 1'b1;
            end
            else
            begin
              shift_reg <= dest_i;
              count_reg <= 6'h00;
              state_reg <= ST_HASH;
            end
          end
        end
        ST_HASH:
        begin
          shift_reg <= {1'b0, shift_reg[47:1]};
          count_reg <= count_reg + 6'h01;
          if (count_reg == `ETHIB_ADDR_LAST_BIT)
            state_reg <= ST_DECIDE;
        end
        ST_DECIDE:
        begin
          accept_o  <= hash_mask_i[crc_value[31:26]]; // see RULE_22
          done_o    <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

endmodule // ethib_addr_filter

// ---- core/ethib_crc32.v ----
`timescale 1ns/1ps
`include "ethib_defs.vh"

module ethib_crc32 #(
  parameter [31:0] POLY = `ETHIB_CRC_POLY,
  parameter [31:0] INIT = `ETHIB_CRC_INIT
) (
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire        clear_i,
  input  wire        bit_valid_i,
  input  wire        bit_i,
  output wire [31:0] crc_o
);

  reg  [31:0] crc_reg;
  wire        feedback;

  // Feedback of the serial generator; bits arrive in transmission order.
  assign feedback = crc_reg[31] ^ bit_i;
  assign crc_o    = crc_reg;

  // Serial CRC register, one bit per clock while bits are offered.
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      crc_reg <= INIT;
    else if (clear_i)
      crc_reg <= INIT;
    else if (bit_valid_i)
      crc_reg <= {crc_reg[30:0], 1'b0} ^ (feedback ? POLY : 32'h00000000); // see RULE_25
  end

endmodule // ethib_crc32

// ---- core/ethib_defs.vh ----
`ifndef ETHIB_DEFS_VH
`define ETHIB_DEFS_VH

// Register byte offsets on the Avalon-MM slave.
`define ETHIB_OFS_CTRL        5'h00
`define ETHIB_OFS_PTR_LOW     5'h04
`define ETHIB_OFS_PTR_HIGH    5'h08
`define ETHIB_OFS_MODE        5'h0C
`define ETHIB_OFS_RX_RING     5'h10
`define ETHIB_OFS_TX_RING     5'h14

// Bit positions in main_control_status.
`define ETHIB_CTRL_INIT       0
`define ETHIB_CTRL_STOP       1
`define ETHIB_CTRL_INIT_DONE  2
`define ETHIB_CTRL_TX_RUN     3
`define ETHIB_CTRL_RX_RUN     4

// Setup block word indices, one 16-bit word each.
`define ETHIB_SW_MODE         4'h0
`define ETHIB_SW_STA0         4'h1
`define ETHIB_SW_STA1         4'h2
`define ETHIB_SW_STA2         4'h3
`define ETHIB_SW_HASH0        4'h4
`define ETHIB_SW_HASH1        4'h5
`define ETHIB_SW_HASH2        4'h6
`define ETHIB_SW_HASH3        4'h7
`define ETHIB_SW_RX_LOW       4'h8
`define ETHIB_SW_RX_HIGH      4'h9
`define ETHIB_SW_TX_LOW       4'hA
`define ETHIB_SW_TX_HIGH      4'hB
`define ETHIB_SETUP_WORDS     12
`define ETHIB_SETUP_LAST      4'hB
`define ETHIB_WORD_STEP       24'h000002

// Mode word bit positions.
`define ETHIB_MODE_ACCEPT_ALL 15
`define ETHIB_MODE_INT_WRAP   6
`define ETHIB_MODE_SINGLE     5
`define ETHIB_MODE_CLASH      4
`define ETHIB_MODE_CRC_OFF    3
`define ETHIB_MODE_LOOP       2
`define ETHIB_MODE_TX_OFF     1
`define ETHIB_MODE_RX_OFF     0

// Ring size field position inside the high ring word.
`define ETHIB_RING_SIZE_MSB   15
`define ETHIB_RING_SIZE_LSB   13

// Transmit attempt limits and loopback frame limits.
`define ETHIB_ATTEMPTS_MAX    5'h10
`define ETHIB_ATTEMPTS_ONE    5'h01
`define ETHIB_LOOP_MAX_DATA   6'h20
`define ETHIB_LOOP_MAX_CRC    3'h4

// Ethernet CRC generator constants and hash timing.
`define ETHIB_CRC_POLY        32'h04C11DB7
`define ETHIB_CRC_INIT        32'hFFFFFFFF
`define ETHIB_ADDR_LAST_BIT   6'h2F

`endif

// ---- core/ethib_top.v ----
//
// Contract
// RULE_01: Init trigger fetches 24-byte setup block by DMA.
// RULE_02: Software gives word-aligned setup pointer in two registers.
// RULE_03: Setup block parsed as twelve fixed 16-bit words.
// RULE_04: Software writes mode zero for normal operation.
// RULE_05: Accept-all mode accepts every destination.
// RULE_06: Software writes mode bits 14 to 7 zero.
// RULE_07: Single attempt: one try, retry failure on clash.
// RULE_08: Forced clash in internal wrap: sixteen attempts, failure.
// RULE_09: CRC off moves CRC logic to receiver.
// RULE_10: Loopback with CRC on: send, store, no check.
// RULE_11: Loopback with CRC off: software CRC, receiver checks.
// RULE_12: Loopback limits frame size, runt filter off.
// RULE_13: Loopback: whole frame in silo first, DMA later.
// RULE_14: Loopback: no transmit chaining, receive chaining kept.
// RULE_15: Internal wrap: no cable drive, no network frames.
// RULE_16: External loopback hashing needs software-supplied CRC.
// RULE_17: Transmitter off keeps transmit-running clear.
// RULE_18: Receiver off keeps receive-running clear, rejects all.
// RULE_19: Software gives unique station address, bit 0 clear.
// RULE_20: Physical destination must equal station address.
// RULE_21: Broadcast destination always accepted.
// RULE_22: Other group addresses filtered by CRC hash index.
// RULE_23: Ring size code gives power-of-two entry count.
// RULE_24: Software aligns ring bases to eight bytes.
// RULE_25: Hash uses standard Ethernet CRC in wire order.
`timescale 1ns/1ps
`include "ethib_defs.vh"

module ethib_top (
  input  wire        CORE_CLK_I,
  input  wire        RST_N_I,
  input  wire [4:0]  AVS_ADDRESS_I,
  input  wire        AVS_READ_I,
  input  wire        AVS_WRITE_I,
  input  wire [31:0] AVS_WRITEDATA_I,
  input  wire [3:0]  AVS_BYTEENABLE_I,
  output reg  [31:0] AVS_READDATA_O,
  output reg         AVS_WAITREQUEST_O,
  output reg         DMA_READ_O,
  output reg  [23:0] DMA_ADDRESS_O,
  input  wire [15:0] DMA_READDATA_I,
  input  wire        DMA_WAITREQUEST_I,
  input  wire        RX_CHECK_I,
  input  wire [47:0] RX_DEST_I,
  input  wire        RX_FROM_NET_I,
  output wire        RX_ACCEPT_O,
  output wire        RX_DONE_O,
  output reg         TX_CRC_APPEND_O,
  output reg         RX_CRC_CHECK_O,
  output reg         RX_CRC_STORE_O,
  output reg         LOOPBACK_O,
  output reg         NET_DRIVE_EN_O,
  output reg         FORCE_CLASH_O,
  output reg  [4:0]  TX_ATTEMPT_LIMIT_O,
  output reg         RUNT_FILTER_EN_O,
  output reg  [5:0]  LOOP_MAX_DATA_O,
  output reg  [2:0]  LOOP_MAX_CRC_O,
  output reg         TX_WHOLE_FIRST_O,
  output reg         RX_DMA_AFTER_END_O,
  output reg         TX_CHAIN_EN_O,
  output reg         TRANSMIT_RUNNING_O,
  output reg         RECEIVE_RUNNING_O,
  output reg  [23:0] RX_RING_BASE_O,
  output reg  [7:0]  RX_RING_ENTRIES_O,
  output reg  [23:0] TX_RING_BASE_O,
  output reg  [7:0]  TX_RING_ENTRIES_O
);

  localparam [2:0] ST_IDLE   = 3'b001;
  localparam [2:0] ST_READ   = 3'b010;
  localparam [2:0] ST_FINISH = 3'b100;

  reg  [15:0] setup_word [0:`ETHIB_SETUP_WORDS-1];
  reg  [2:0]  state_reg;
  reg  [3:0]  word_idx_reg;
  reg  [15:0] ptr_low_reg;
  reg  [7:0]  ptr_high_reg;
  reg         init_done_reg;
  reg         tx_running_reg;
  reg         rx_running_reg;
  reg  [31:0] read_next;
  wire [15:0] mode_word;
  wire [47:0] station_address;
  wire [63:0] group_hash_mask;
  wire [23:0] rx_ring_base;
  wire [2:0]  rx_ring_size_log2;
  wire [23:0] tx_ring_base;
  wire [2:0]  tx_ring_size_log2;
  wire        accept_all_frames;
  wire        internal_wrap_select;
  wire        single_attempt;
  wire        forced_clash_test;
  wire        crc_generation_off;
  wire        loopback_on;
  wire        transmitter_off;
  wire        receiver_off;
  wire        bus_request;
  wire        bus_write;
  wire        ctrl_write;
  wire        busy;
  wire        start_init;
  wire        stop_now;
  wire        word_taken;
  integer     i;

  // Fixed word layout of the fetched setup block.
  assign mode_word         = setup_word[`ETHIB_SW_MODE]; // see RULE_03
  assign station_address   = {setup_word[`ETHIB_SW_STA2], setup_word[`ETHIB_SW_STA1],
                              setup_word[`ETHIB_SW_STA0]};
  assign group_hash_mask   = {setup_word[`ETHIB_SW_HASH3], setup_word[`ETHIB_SW_HASH2],
                              setup_word[`ETHIB_SW_HASH1], setup_word[`ETHIB_SW_HASH0]};
  assign rx_ring_base      = {setup_word[`ETHIB_SW_RX_HIGH][7:0], setup_word[`ETHIB_SW_RX_LOW]};
  assign rx_ring_size_log2 = setup_word[`ETHIB_SW_RX_HIGH][`ETHIB_RING_SIZE_MSB:`ETHIB_RING_SIZE_LSB];
  assign tx_ring_base      = {setup_word[`ETHIB_SW_TX_HIGH][7:0], setup_word[`ETHIB_SW_TX_LOW]};
  assign tx_ring_size_log2 = setup_word[`ETHIB_SW_TX_HIGH][`ETHIB_RING_SIZE_MSB:`ETHIB_RING_SIZE_LSB];

  // Mode bits; reserved bits 14 to 7 are not decoded.
  assign accept_all_frames    = mode_word[`ETHIB_MODE_ACCEPT_ALL];
  assign internal_wrap_select = mode_word[`ETHIB_MODE_INT_WRAP];
  assign single_attempt       = mode_word[`ETHIB_MODE_SINGLE];
  assign forced_clash_test    = mode_word[`ETHIB_MODE_CLASH];
  assign crc_generation_off   = mode_word[`ETHIB_MODE_CRC_OFF];
  assign loopback_on          = mode_word[`ETHIB_MODE_LOOP];
  assign transmitter_off      = mode_word[`ETHIB_MODE_TX_OFF];
  assign receiver_off         = mode_word[`ETHIB_MODE_RX_OFF];

  // Bus decode; a write lands in the cycle its wait state is lifted.
  assign bus_request = AVS_READ_I || AVS_WRITE_I;
  assign bus_write   = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  assign ctrl_write  = bus_write && (AVS_ADDRESS_I == `ETHIB_OFS_CTRL) && AVS_BYTEENABLE_I[0];
  assign busy        = (state_reg != ST_IDLE);
  assign start_init  = ctrl_write && !busy && AVS_WRITEDATA_I[`ETHIB_CTRL_INIT];
  assign stop_now    = ctrl_write && !busy && !AVS_WRITEDATA_I[`ETHIB_CTRL_INIT] &&
                       AVS_WRITEDATA_I[`ETHIB_CTRL_STOP];
  assign word_taken  = (state_reg == ST_READ) && DMA_READ_O && !DMA_WAITREQUEST_I;

  // Read data multiplexer; unmapped offsets read as zero.
  always @*
  begin
    read_next = 32'h00000000;
    case (AVS_ADDRESS_I)
      `ETHIB_OFS_CTRL:
      begin
        read_next[`ETHIB_CTRL_INIT]      = busy;
        read_next[`ETHIB_CTRL_INIT_DONE] = init_done_reg;
        read_next[`ETHIB_CTRL_TX_RUN]    = tx_running_reg;
        read_next[`ETHIB_CTRL_RX_RUN]    = rx_running_reg;
      end
      `ETHIB_OFS_PTR_LOW:  read_next[15:0] = ptr_low_reg;
      `ETHIB_OFS_PTR_HIGH: read_next[7:0]  = ptr_high_reg;
      `ETHIB_OFS_MODE:     read_next[15:0] = mode_word;
      `ETHIB_OFS_RX_RING:  read_next = {rx_ring_size_log2, 5'h00, rx_ring_base};
      `ETHIB_OFS_TX_RING:  read_next = {tx_ring_size_log2, 5'h00, tx_ring_base};
      default:             read_next = 32'h00000000;
    endcase
  end

  // One wait state per access, then read data is presented with the release.
  always @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O    <= 32'h00000000;
    end
    else
    begin
      AVS_WAITREQUEST_O <= !(bus_request && AVS_WAITREQUEST_O);
      if (AVS_READ_I && AVS_WAITREQUEST_O)
        AVS_READDATA_O <= read_next;
    end
  end

  // Setup pointer registers; the low bit is held at zero.
  always @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      ptr_low_reg  <= 16'h0000;
      ptr_high_reg <= 8'h00;
    end
    else if (bus_write)
    begin
      if (AVS_ADDRESS_I == `ETHIB_OFS_PTR_LOW)
      begin
        if (AVS_BYTEENABLE_I[0])
          ptr_low_reg[7:0] <= {AVS_WRITEDATA_I[7:1], 1'b0}; // see RULE_02
        if (AVS_BYTEENABLE_I[1])
          ptr_low_reg[15:8] <= AVS_WRITEDATA_I[15:8];
      end
      if ((AVS_ADDRESS_I == `ETHIB_OFS_PTR_HIGH) && AVS_BYTEENABLE_I[0])
        ptr_high_reg <= AVS_WRITEDATA_I[7:0];
    end
  end

  // Setup fetch sequencer; each word is held on the DMA port until taken.
  always @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      state_reg     <= ST_IDLE;
      word_idx_reg  <= 4'h0;
      DMA_READ_O    <= 1'b0;
      DMA_ADDRESS_O <= 24'h000000;
      for (i = 0; i < `ETHIB_SETUP_WORDS; i = i + 1)
        setup_word[i] <= 16'h0000;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (start_init)
          begin
            state_reg     <= ST_READ; // see RULE_01
            word_idx_reg  <= 4'h0;
            DMA_READ_O    <= 1'b1;
            DMA_ADDRESS_O <= {ptr_high_reg, ptr_low_reg[15:1], 1'b0};
          end
        end
        ST_READ:
        begin
          if (word_taken)
          begin
            setup_word[word_idx_reg] <= DMA_READDATA_I; // see RULE_03
            if (word_idx_reg == `ETHIB_SETUP_LAST)
            begin
              DMA_READ_O <= 1'b0;
              state_reg  <= ST_FINISH;
            end
            else
            begin
              word_idx_reg  <= word_idx_reg + 4'h1;
              DMA_ADDRESS_O <= DMA_ADDRESS_O + `ETHIB_WORD_STEP;
            end
          end
        end
        ST_FINISH:
          state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Status flags; init-done set wins over a write-one clear.
  always @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      init_done_reg  <= 1'b0;
      tx_running_reg <= 1'b0;
      rx_running_reg <= 1'b0;
    end
    else
    begin
      if (state_reg == ST_FINISH)
      begin
        init_done_reg  <= 1'b1;
        tx_running_reg <= !transmitter_off; // see RULE_17
        rx_running_reg <= !receiver_off; // see RULE_18
      end
      else
      begin
        if (ctrl_write && AVS_WRITEDATA_I[`ETHIB_CTRL_INIT_DONE])
          init_done_reg <= 1'b0;
        if (start_init || stop_now)
        begin
          tx_running_reg <= 1'b0;
          rx_running_reg <= 1'b0;
        end
      end
    end
  end

  // Mode-derived controls for the data path, refreshed when a fetch ends.
  always @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      TX_CRC_APPEND_O    <= 1'b0;
      RX_CRC_CHECK_O     <= 1'b0;
      RX_CRC_STORE_O     <= 1'b0;
      LOOPBACK_O         <= 1'b0;
      NET_DRIVE_EN_O     <= 1'b0;
      FORCE_CLASH_O      <= 1'b0;
      TX_ATTEMPT_LIMIT_O <= `ETHIB_ATTEMPTS_MAX;
      RUNT_FILTER_EN_O   <= 1'b1;
      LOOP_MAX_DATA_O    <= 6'h00;
      LOOP_MAX_CRC_O     <= 3'h0;
      TX_WHOLE_FIRST_O   <= 1'b0;
      RX_DMA_AFTER_END_O <= 1'b0;
      TX_CHAIN_EN_O      <= 1'b1;
      RX_RING_BASE_O     <= 24'h000000;
      RX_RING_ENTRIES_O  <= 8'h01;
      TX_RING_BASE_O     <= 24'h000000;
      TX_RING_ENTRIES_O  <= 8'h01;
    end
    else if (state_reg == ST_FINISH)
    begin
      TX_CRC_APPEND_O    <= !crc_generation_off; // see RULE_09
      RX_CRC_CHECK_O     <= !(loopback_on && !crc_generation_off); // see RULE_10 see RULE_11
      RX_CRC_STORE_O     <= loopback_on && !crc_generation_off; // see RULE_10
      LOOPBACK_O         <= loopback_on; // see RULE_12
      NET_DRIVE_EN_O     <= !(loopback_on && internal_wrap_select); // see RULE_15
      FORCE_CLASH_O      <= forced_clash_test && loopback_on && internal_wrap_select; // see RULE_08
      TX_ATTEMPT_LIMIT_O <= single_attempt ? `ETHIB_ATTEMPTS_ONE : `ETHIB_ATTEMPTS_MAX; // see RULE_07
      RUNT_FILTER_EN_O   <= !loopback_on; // see RULE_12
      LOOP_MAX_DATA_O    <= loopback_on ? `ETHIB_LOOP_MAX_DATA : 6'h00; // see RULE_12
      LOOP_MAX_CRC_O     <= loopback_on ? `ETHIB_LOOP_MAX_CRC : 3'h0;
      TX_WHOLE_FIRST_O   <= loopback_on; // see RULE_13
      RX_DMA_AFTER_END_O <= loopback_on; // see RULE_13
      TX_CHAIN_EN_O      <= !loopback_on; // see RULE_14
      RX_RING_BASE_O     <= rx_ring_base;
      RX_RING_ENTRIES_O  <= 8'h01 << rx_ring_size_log2; // see RULE_23
      TX_RING_BASE_O     <= tx_ring_base;
      TX_RING_ENTRIES_O  <= 8'h01 << tx_ring_size_log2; // see RULE_23
    end
  end

  // Running flags mirrored to the ports.
  always @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      TRANSMIT_RUNNING_O <= 1'b0;
      RECEIVE_RUNNING_O  <= 1'b0;
    end
    else
    begin
      TRANSMIT_RUNNING_O <= tx_running_reg;
      RECEIVE_RUNNING_O  <= rx_running_reg;
    end
  end

  // Destination address filter for incoming frames.
  ethib_addr_filter u_filter (
    .clk_i           (CORE_CLK_I),
    .rst_n_i         (RST_N_I),
    .check_i         (RX_CHECK_I),
    .dest_i          (RX_DEST_I),
    .from_net_i      (RX_FROM_NET_I),
    .rx_enable_i     (rx_running_reg),
    .accept_all_i    (accept_all_frames),
    .internal_only_i (loopback_on && internal_wrap_select),
    .station_i       (station_address),
    .hash_mask_i     (group_hash_mask),
    .accept_o        (RX_ACCEPT_O),
    .done_o          (RX_DONE_O)
  );

endmodule // ethib_top

// ---- verification/ethib_checker.sv ----
`timescale 1ns/1ps
module ethib_checker (
  input wire        CORE_CLK_I,
  input wire        RST_N_I,
  input wire        AVS_READ_I,
  input wire        AVS_WRITE_I,
  input wire        AVS_WAITREQUEST_O,
  input wire        DMA_READ_O,
  input wire [23:0] DMA_ADDRESS_O,
  input wire        DMA_WAITREQUEST_I,
  input wire        RX_CHECK_I,
  input wire        RX_ACCEPT_O,
  input wire        RX_DONE_O,
  input wire        RECEIVE_RUNNING_O,
  input wire        LOOPBACK_O,
  input wire        NET_DRIVE_EN_O,
  input wire        FORCE_CLASH_O,
  input wire        RUNT_FILTER_EN_O,
  input wire [5:0]  LOOP_MAX_DATA_O,
  input wire        TX_CHAIN_EN_O
);
  logic [3:0] word_cnt;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  // Counts setup words taken in one fetch, cleared once the fetch has ended.
  always @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I || (!DMA_READ_O && !$past(DMA_READ_O)))
      word_cnt <= 4'h0;
    else if (DMA_READ_O && !DMA_WAITREQUEST_I)
      word_cnt <= word_cnt + 4'h1;
  end

  sequence s_word_taken;
    DMA_READ_O && !DMA_WAITREQUEST_I;
  endsequence

  a_wait_drops: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("waitrequest stayed high");
  a_wait_short: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low too long");
  a_dma_hold: assert property (DMA_READ_O && DMA_WAITREQUEST_I |=> DMA_READ_O && $stable(DMA_ADDRESS_O))
    else $error("dma request moved");
  a_dma_step: assert property (s_word_taken ##1 DMA_READ_O |-> DMA_ADDRESS_O == $past(DMA_ADDRESS_O) + 24'h2)
    else $error("dma address step wrong");
  a_twelve_words: assert property ($fell(DMA_READ_O) |-> word_cnt == 4'hC)
    else $error("fetch word count wrong");
  a_done_pulse: assert property (RX_DONE_O |=> !RX_DONE_O)
    else $error("done longer than a cycle");
  a_rx_off_reject: assert property (RX_CHECK_I && !RECEIVE_RUNNING_O |=> RX_DONE_O && !RX_ACCEPT_O)
    else $error("receiver off accepted");
  a_clash_wrap: assert property (FORCE_CLASH_O |-> LOOPBACK_O && !NET_DRIVE_EN_O)
    else $error("clash outside internal wrap");
  a_loop_limits: assert property (LOOPBACK_O |-> LOOP_MAX_DATA_O == 6'h20 && !RUNT_FILTER_EN_O && !TX_CHAIN_EN_O)
    else $error("loopback limits wrong");
endmodule // ethib_checker

bind ethib_top ethib_checker ethib_checker_inst (.*);

// ---- verification/ethib_mem_model.sv ----
`timescale 1ns/1ps
module ethib_mem_model (
  input  wire        clk_i,
  input  wire        dma_read_i,
  input  wire [23:0] dma_address_i,
  input  wire        slow_i,
  output reg  [15:0] dma_readdata_o,
  output reg         dma_waitrequest_o
);
  logic [15:0] mem [0:2047];
  logic [15:0] junk = 16'h0000;
  integer      seed = 32'h1C3A5E7F;

  // Stalls at random when slow; the junk pattern moves every cycle so stale data never looks valid.
  always @(posedge clk_i)
  begin
    dma_waitrequest_o <= slow_i && (($random(seed) & 32'h1) != 0);
    junk <= junk + 16'h3B1D;
  end

  // The addressed word shows only in the cycle that accepts the read.
  always @*
  begin
    dma_readdata_o = (dma_read_i && !dma_waitrequest_o) ? mem[dma_address_i[11:1]] : junk;
  end
endmodule // ethib_mem_model

// ---- verification/ethib_top_test.sv ----
`timescale 1ns/1ps
module ethib_top_test;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic [4:0]   a = 5'h00;
  logic         rd = 1'b0;
  logic         wr = 1'b0;
  logic [31:0]  wd = 32'h0;
  logic         chk = 1'b0;
  logic [47:0]  dst = 48'h0;
  logic         net = 1'b0;
  logic         slow = 1'b0;
  wire  [31:0]  rdat;
  wire  [23:0]  da, rxb, txb;
  wire  [15:0]  dd;
  wire  [7:0]   rxe, txe;
  wire  [5:0]   lmd;
  wire  [4:0]   lim;
  wire  [2:0]   lmc;
  wire          wq, dr, dw, acc, done, app, cck, sto, lb, nde, fc, runt, whl, aft, chn, txr, rxr;
  integer       seed = 32'hA9FC6862;
  integer       bad_count = 0;
  integer       n_tests = 0;
  integer       cyc = 0;
  logic [31:0]  q;
  logic [15:0]  md;
  logic [47:0]  sta;
  logic [63:0]  hm;
  logic [23:0]  p, rb, tb;
  logic [2:0]   rc, tc;
  logic [191:0] blk;
  logic [15:0]  modes [0:7] = '{16'h0000, 16'h8000, 16'h0020, 16'h0054, 16'h000C, 16'h0004, 16'h0002, 16'h0001};

  ethib_top ethib_top_inst (.CORE_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(a), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wq), .DMA_READ_O(dr), .DMA_ADDRESS_O(da), .DMA_READDATA_I(dd),
    .DMA_WAITREQUEST_I(dw), .RX_CHECK_I(chk), .RX_DEST_I(dst), .RX_FROM_NET_I(net), .RX_ACCEPT_O(acc),
    .RX_DONE_O(done), .TX_CRC_APPEND_O(app), .RX_CRC_CHECK_O(cck), .RX_CRC_STORE_O(sto), .LOOPBACK_O(lb),
    .NET_DRIVE_EN_O(nde), .FORCE_CLASH_O(fc), .TX_ATTEMPT_LIMIT_O(lim), .RUNT_FILTER_EN_O(runt),
    .LOOP_MAX_DATA_O(lmd), .LOOP_MAX_CRC_O(lmc), .TX_WHOLE_FIRST_O(whl), .RX_DMA_AFTER_END_O(aft),
    .TX_CHAIN_EN_O(chn), .TRANSMIT_RUNNING_O(txr), .RECEIVE_RUNNING_O(rxr), .RX_RING_BASE_O(rxb),
    .RX_RING_ENTRIES_O(rxe), .TX_RING_BASE_O(txb), .TX_RING_ENTRIES_O(txe));
  ethib_mem_model ethib_mem_model_inst (.clk_i(clk), .dma_read_i(dr), .dma_address_i(da), .slow_i(slow),
    .dma_readdata_o(dd), .dma_waitrequest_o(dw));

  // Free-running core clock.
  initial
  begin
    forever #20 clk = ~clk;
  end

  task automatic cmp(input [95:0] got, input [95:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One register access; held until waitrequest is seen low, read data taken at that edge.
  task automatic av(input [4:0] adr, input w, input [31:0] d);
    @(posedge clk);
    a <= adr;
    wr <= w;
    rd <= !w;
    wd <= d;
    @(posedge clk);
    while (wq !== 1'b0)
      @(posedge clk);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Expected receive decision, with the group hash from a serial CRC fed in wire order.
  function automatic logic want(input [47:0] d, input n);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < 48; i++)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? 32'h04C11DB7 : 32'h0);
    if (md[0] || (md[6] && md[2] && n))
      return 1'b0;
    if (md[15])
      return 1'b1;
    if (!d[0])
      return d == sta;
    if (&d)
      return 1'b1;
    return hm[c[31:26]];
  endfunction

  // Expected control levels and ring set-up after a fetch of mode m.
  function automatic logic [88:0] ctl(input [15:0] m);
    return {m[5] ? 5'h01 : 5'h10, !m[3], m[2], m[2] & m[6] & m[4], !m[2], m[2] ? 6'h20 : 6'h00,
            m[2] ? 3'h4 : 3'h0, m[2], m[2], !m[2], !m[1], !m[0], !(m[2] & !m[3]), m[2] & !m[3],
            rb, 8'h01 << rc, tb, 8'h01 << tc};
  endfunction

  task automatic filt(input [47:0] d, input n);
    @(posedge clk);
    dst <= d;
    net <= n;
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
    for (int i = 0; i < 60 && done !== 1'b1; i++)
      @(posedge clk);
    cmp({done, acc}, {1'b1, want(d, n)});
  endtask

  // Cuts a hung run short.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      bad_count++;
      tally_and_finish;
    end
  end

  // Reset, then one fetch and a set of receive checks for every mode.
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    av(5'h18, 1'b0, 32'h0);
    cmp(q, 0);
    for (int k = 0; k < 8; k++)
    begin
      md = modes[k];
      sta = {16'($random(seed)), 31'($random(seed)), 1'b0};
      hm = {$random(seed), $random(seed)};
      rb = {21'($random(seed)), 3'h0};
      tb = {21'($random(seed)), 3'h0};
      rc = 3'($random(seed));
      tc = 3'($random(seed));
      p = {8'($random(seed)), 4'h0, 6'($random(seed)), 6'h00};
      blk = {tc, 5'h0, tb[23:16], tb[15:0], rc, 5'h0, rb[23:16], rb[15:0], hm, sta, md};
      for (int j = 0; j < 12; j++)
        ethib_mem_model_inst.mem[p[11:1] + j] = blk[16 * j +: 16];
      slow <= k[0];
      av(5'h04, 1'b1, {16'h0, p[15:0] | 16'h0001});
      av(5'h08, 1'b1, {24'h0, p[23:16]});
      av(5'h04, 1'b0, 32'h0);
      cmp(q, {16'h0, p[15:0]});
      av(5'h00, 1'b1, 32'h5);
      q = 32'h0;
      for (int t = 0; t < 100 && q[2] !== 1'b1; t++)
        av(5'h00, 1'b0, 32'h0);
      cmp(q[4:2], {!md[0], !md[1], 1'b1});
      av(5'h0C, 1'b0, 32'h0);
      cmp(q, {16'h0, md});
      av(5'h10, 1'b0, 32'h0);
      cmp(q, {rc, 5'h0, rb});
      av(5'h14, 1'b0, 32'h0);
      cmp(q, {tc, 5'h0, tb});
      cmp({lim, app, lb, fc, runt, lmd, lmc, whl, aft, chn, txr, rxr, cck, sto, rxb, rxe, txb, txe},
          ctl(md));
      filt(sta, 1'b0);
      filt(sta ^ 48'h800000000000, 1'b1);
      filt(48'hFFFFFFFFFFFF, 1'b1);
      repeat (3) filt({47'($random(seed)), 1'b1}, 1'b0);
    end
    av(5'h00, 1'b1, 32'h2);
    av(5'h00, 1'b0, 32'h0);
    cmp(q[4:3], 2'b00);
    tally_and_finish;
  end
endmodule // ethib_top_test
